// File: rtl/scr_defs.svh
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

`define SCR_ADDR_WAIT_PERIOD 8'h03
`define SCR_ADDR_PERSIST 8'h0c
`define SCR_ADDR_WAIT_EXT 8'h0d
`define SCR_ADDR_PULSE_NUM 8'h0e
`define SCR_ADDR_ANALOG 8'h0f

`define SCR_RST_WAIT_PERIOD 8'hff
`define SCR_RST_PERSIST 8'h00
`define SCR_RST_WAIT_EXT 8'h00
`define SCR_RST_PULSE_NUM 8'h00
`define SCR_RST_ANALOG 8'h00

`define SCR_BIT_WAIT_STRETCH 1
`define SCR_CLR_PERS_LSB 0
`define SCR_PRX_PERS_LSB 4
`define SCR_PERS_W 4
`define SCR_DRIVE_MSB 7
`define SCR_DRIVE_LSB 6
`define SCR_GAIN_MSB 1
`define SCR_GAIN_LSB 0

`define SCR_WAIT_FULL 9'h100
`define SCR_STRETCH_LAST 4'hb
`define SCR_TARGET_STEP 6'h05
`define SCR_TARGET_BASE 4'h3

`define SCR_CLK_PERIOD_NS 100
`define SCR_WAIT_STEP_US 2400
`define SCR_LED_ON_NS 8000
`define SCR_LED_OFF_NS 8000

`endif

// File: rtl/scr_pkg.sv
package scr_pkg;
  typedef enum logic [1:0] {
    SCR_LED_IDLE = 2'h0,
    SCR_LED_ON = 2'h1,
    SCR_LED_OFF = 2'h3
  } scr_led_e;

  typedef struct packed {
    logic done;
    logic out_of_range;
  } scr_result_s;

  typedef struct packed {
    logic [1:0] led_drive_strength;
    logic [1:0] colour_gain;
  } scr_analog_s;
endpackage

// File: rtl/scr_config_regs.sv
// Function
// RULE1 - clear persistence zero: interrupt at end of every colour cycle.
// RULE2 - clear persistence one: interrupt on a single out-of-window clear result.
// RULE3 - codes 2..15 need 2,3,5,10..60 consecutive out-of-window results.
// RULE4 - an in-window result restarts the consecutive count.
// RULE5 - proximity has its own persistence filter in bits 7:4.
// RULE6 - wait periods run in 2.4 ms steps from the two's-complement value.
// RULE7 - wait-stretch bit 1 makes every wait period twelve times longer.
// RULE8 - host writes zeros to configuration bits 7:2 and 0.
// RULE9 - each proximity cycle emits pulse-count LED pulses; reset value zero.
// RULE10 - drive code sets LED current 100 mA halving; gain 1x,4x,16x,60x.
// RULE11 - host writes zeros to control bits 5:2.
`timescale 1ns/10ps
`default_nettype none
`include "scr_defs.svh"
module scr_config_regs
  import scr_pkg::*;
#(
  parameter int unsigned WAIT_STEP_CYCLES =
    (`SCR_WAIT_STEP_US * 1000) / `SCR_CLK_PERIOD_NS
)
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  input wire scr_result_s i_clear_result,
  input wire scr_result_s i_prox_result,
  output logic o_clear_irq,
  output logic o_prox_irq,
  input wire logic i_wait_start,
  output logic o_wait_busy,
  output logic o_wait_done,
  input wire logic i_prox_start,
  output logic o_led_pulse,
  output logic o_led_busy,
  output scr_analog_s o_analog
);
  localparam int unsigned LED_ON_CYCLES =
    (`SCR_LED_ON_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS;
  localparam int unsigned LED_OFF_CYCLES =
    (`SCR_LED_OFF_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS;

  logic [7:0] wait_period_r;
  logic [7:0] persist_r;
  logic wait_stretch_r;
  logic [7:0] pulse_num_r;
  scr_analog_s analog_r;

  wire wr_wait = i_wr_en && (i_wr_addr == `SCR_ADDR_WAIT_PERIOD);
  wire wr_pers = i_wr_en && (i_wr_addr == `SCR_ADDR_PERSIST);
  wire wr_ext = i_wr_en && (i_wr_addr == `SCR_ADDR_WAIT_EXT);
  wire wr_pulse = i_wr_en && (i_wr_addr == `SCR_ADDR_PULSE_NUM);
  wire wr_analog = i_wr_en && (i_wr_addr == `SCR_ADDR_ANALOG);

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wait_period_r <= `SCR_RST_WAIT_PERIOD;
      persist_r <= `SCR_RST_PERSIST;
      wait_stretch_r <= 1'(`SCR_RST_WAIT_EXT >> `SCR_BIT_WAIT_STRETCH);
      pulse_num_r <= `SCR_RST_PULSE_NUM; // [RULE9]
      analog_r <= {2'(`SCR_RST_ANALOG >> `SCR_DRIVE_LSB), 2'(`SCR_RST_ANALOG >> `SCR_GAIN_LSB)};
    end
    else
    begin
      if (wr_wait) wait_period_r <= i_wr_data;
      if (wr_pers) persist_r <= i_wr_data;
      // reserved bits are not stored and read back as zero
      if (wr_ext) wait_stretch_r <= i_wr_data[`SCR_BIT_WAIT_STRETCH]; // [RULE8]
      if (wr_pulse) pulse_num_r <= i_wr_data;
      if (wr_analog) analog_r <= {i_wr_data[`SCR_DRIVE_MSB:`SCR_DRIVE_LSB],
                                  i_wr_data[`SCR_GAIN_MSB:`SCR_GAIN_LSB]}; // [RULE11]
    end
  end

  // drive code: current is 100 mA shifted right by the code
  assign o_analog = analog_r; // [RULE10]

  logic [7:0] rd_sel;
  logic [7:0] rd_data_r;
  assign rd_sel =
    (i_rd_addr == `SCR_ADDR_WAIT_PERIOD) ? wait_period_r :
    (i_rd_addr == `SCR_ADDR_PERSIST) ? persist_r :
    (i_rd_addr == `SCR_ADDR_WAIT_EXT) ?
      (8'h00 | (8'(wait_stretch_r) << `SCR_BIT_WAIT_STRETCH)) :
    (i_rd_addr == `SCR_ADDR_PULSE_NUM) ? pulse_num_r :
    (i_rd_addr == `SCR_ADDR_ANALOG) ?
      {analog_r.led_drive_strength, 4'h0, analog_r.colour_gain} :
    8'h00;

  always_ff @(posedge i_clock)
  begin
    if (i_srst) rd_data_r <= 8'h00;
    else if (i_rd_en) rd_data_r <= rd_sel;
  end
  assign o_rd_data = rd_data_r;

  // persistence filters: channel 0 clear, channel 1 proximity
  logic [5:0] pers_cnt_r [2];
  logic [5:0] pers_target [2];
  logic [1:0] pers_irq_r;
  scr_result_s pers_res [2];
  wire [3:0] clr_code = persist_r[`SCR_CLR_PERS_LSB +: `SCR_PERS_W];
  wire [3:0] prx_code = persist_r[`SCR_PRX_PERS_LSB +: `SCR_PERS_W];
  assign pers_res[0] = i_clear_result;
  assign pers_res[1] = i_prox_result;
  // clear codes above 3 step in fives
  assign pers_target[0] = (clr_code <= `SCR_TARGET_BASE) ? {2'h0, clr_code} :
    6'((clr_code - `SCR_TARGET_BASE) * `SCR_TARGET_STEP); // [RULE3]
  assign pers_target[1] = {2'h0, prx_code}; // [RULE5]

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pers
      wire [5:0] cnt_inc = pers_cnt_r[g] + 6'h01;
      wire every = pers_target[g] == 6'h00;
      wire hit = pers_res[g].out_of_range && (cnt_inc >= pers_target[g]);
      always_ff @(posedge i_clock)
      begin
        if (i_srst)
        begin
          pers_cnt_r[g] <= 6'h00;
          pers_irq_r[g] <= 1'b0;
        end
        else
        begin
          pers_irq_r[g] <= pers_res[g].done && (every || hit); // [RULE1] [RULE2] [RULE3]
          if (pers_res[g].done)
          begin
            if (!pers_res[g].out_of_range) pers_cnt_r[g] <= 6'h00; // [RULE4]
            else if (!hit) pers_cnt_r[g] <= cnt_inc;
          end
        end
      end
    end
  endgenerate
  assign o_clear_irq = pers_irq_r[0];
  assign o_prox_irq = pers_irq_r[1];

  // wait timer
  logic wait_busy_r;
  logic wait_done_r;
  logic [31:0] step_cnt_r;
  logic [3:0] sub_cnt_r;
  logic [8:0] per_cnt_r;
  logic [8:0] per_total_r;
  wire step_tick = wait_busy_r && (step_cnt_r == WAIT_STEP_CYCLES - 1);
  wire [3:0] sub_last = wait_stretch_r ? `SCR_STRETCH_LAST : 4'h0;
  wire sub_tick = step_tick && (sub_cnt_r == sub_last);
  wire per_end = sub_tick && (per_cnt_r == per_total_r - 9'h001);

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wait_busy_r <= 1'b0;
      wait_done_r <= 1'b0;
      step_cnt_r <= 32'h0;
      sub_cnt_r <= 4'h0;
      per_cnt_r <= 9'h000;
      per_total_r <= 9'h000;
    end
    else
    begin
      wait_done_r <= per_end;
      if (i_wait_start && !wait_busy_r)
      begin
        wait_busy_r <= 1'b1;
        step_cnt_r <= 32'h0;
        sub_cnt_r <= 4'h0;
        per_cnt_r <= 9'h000;
        per_total_r <= `SCR_WAIT_FULL - {1'b0, wait_period_r}; // [RULE6]
      end
      else if (wait_busy_r)
      begin
        step_cnt_r <= step_tick ? 32'h0 : step_cnt_r + 32'h1;
        if (step_tick) sub_cnt_r <= sub_tick ? 4'h0 : sub_cnt_r + 4'h1; // [RULE7]
        if (sub_tick) per_cnt_r <= per_cnt_r + 9'h001;
        if (per_end) wait_busy_r <= 1'b0;
      end
    end
  end
  assign o_wait_busy = wait_busy_r;
  assign o_wait_done = wait_done_r;

  // led pulse train
  scr_led_e led_r;
  scr_led_e led_nxt;
  logic [7:0] left_r;
  logic [15:0] led_cnt_r;
  wire on_end = led_cnt_r == 16'(LED_ON_CYCLES - 1);
  wire off_end = led_cnt_r == 16'(LED_OFF_CYCLES - 1);

  always_comb
  begin
    led_nxt = led_r;
    unique case (led_r)
      SCR_LED_IDLE: if (i_prox_start && pulse_num_r != 8'h00) led_nxt = SCR_LED_ON;
      SCR_LED_ON: if (on_end) led_nxt = SCR_LED_OFF;
      SCR_LED_OFF: if (off_end) led_nxt = (left_r == 8'h00) ? SCR_LED_IDLE : SCR_LED_ON;
      default: led_nxt = SCR_LED_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      led_r <= SCR_LED_IDLE;
      left_r <= 8'h00;
      led_cnt_r <= 16'h0;
    end
    else
    begin
      led_r <= led_nxt;
      led_cnt_r <= (led_nxt != led_r) ? 16'h0 : led_cnt_r + 16'h1;
      if (led_r == SCR_LED_IDLE && led_nxt == SCR_LED_ON)
        left_r <= pulse_num_r - 8'h01; // [RULE9]
      else if (led_r == SCR_LED_OFF && led_nxt == SCR_LED_ON)
        left_r <= left_r - 8'h01;
    end
  end
  assign o_led_pulse = led_r == SCR_LED_ON;
  assign o_led_busy = led_r != SCR_LED_IDLE;

  // helper: pulses seen in the current train
  logic [8:0] seen_r;
  logic [7:0] asked_r;
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      seen_r <= 9'h000;
      asked_r <= 8'h00;
    end
    else if (led_r == SCR_LED_IDLE && led_nxt == SCR_LED_ON)
    begin
      seen_r <= 9'h001;
      asked_r <= pulse_num_r;
    end
    else if (led_r == SCR_LED_OFF && led_nxt == SCR_LED_ON)
      seen_r <= seen_r + 9'h001;
  end

  sequence s_train_end;
    led_r == SCR_LED_OFF ##1 led_r == SCR_LED_IDLE;
  endsequence

  every_cycle_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE1]
    i_clear_result.done && clr_code == 4'h0 |=> o_clear_irq)
    else $error("clear code zero missed an interrupt");
  single_oor_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE2]
    i_clear_result.done && i_clear_result.out_of_range && clr_code == 4'h1 |=> o_clear_irq)
    else $error("single out-of-range result did not interrupt");
  run_target_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE3]
    o_clear_irq && $past(clr_code) >= 4'h2 |->
      ($past(pers_cnt_r[0]) + 6'h01) >= $past(pers_target[0]))
    else $error("clear interrupt before the run reached its target");
  run_restart_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE4]
    i_clear_result.done && !i_clear_result.out_of_range && clr_code != 4'h0
      |=> pers_cnt_r[0] == 6'h00 && !o_clear_irq)
    else $error("in-window result did not restart the run");
  prox_filter_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE5]
    i_prox_result.done && i_prox_result.out_of_range && prx_code == 4'h1
      && !i_clear_result.done |=> o_prox_irq && !o_clear_irq)
    else $error("proximity filter not independent");
  wait_end_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE6]
    step_tick && !wait_stretch_r && per_cnt_r == per_total_r - 9'h001
      |=> o_wait_done && !o_wait_busy)
    else $error("wait period did not end on its last step");
  wait_stretch_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE7]
    step_tick && wait_stretch_r && sub_cnt_r < `SCR_STRETCH_LAST |=> o_wait_busy && !o_wait_done)
    else $error("stretched wait ended early");
  pulse_count_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE9]
    s_train_end |-> {1'b0, asked_r} == $past(seen_r))
    else $error("wrong number of led pulses");
  drive_field_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE10]
    wr_analog |=> o_analog.led_drive_strength == $past(i_wr_data[`SCR_DRIVE_MSB:`SCR_DRIVE_LSB])
      && o_analog.colour_gain == $past(i_wr_data[`SCR_GAIN_MSB:`SCR_GAIN_LSB]))
    else $error("analog settings not taken from the write");
endmodule
`default_nettype wire

// File: verification/scr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "scr_defs.svh"
module scr_host_model (
  input wire logic i_clock,
  output logic o_wr_en,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_rd_en,
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data
);
  initial
  begin
    o_wr_en = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = 8'h00;
    o_rd_en = 1'b0;
    o_rd_addr = 8'h00;
  end
  // raw set: reserved bits go out as given
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic raw);
    logic [7:0] m = 8'hff;
    if (!raw && a == `SCR_ADDR_WAIT_EXT)
      m = 8'h02;
    if (!raw && a == `SCR_ADDR_ANALOG)
      m = 8'hc3;
    @(posedge i_clock);
    o_wr_en <= 1'b1;
    o_wr_addr <= a;
    o_wr_data <= d & m;
    @(posedge i_clock);
    o_wr_en <= 1'b0;
    o_wr_addr <= ~a;
    o_wr_data <= ~(d & m);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_clock);
    o_rd_en <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_clock);
    o_rd_en <= 1'b0;
    o_rd_addr <= ~a;
    #1 q = i_rd_data;
  endtask
endmodule
`default_nettype wire

// File: verification/sensor_config_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "scr_defs.svh"
module sensor_config_regs_test
  import scr_pkg::*;
;
  logic clk, srst, wr_en, rd_en, wst, pst;
  logic [7:0] wa, wd, ra, rdd;
  scr_result_s clr, prx;
  logic cirq, pirq, wbusy, wdone, lp, lbusy;
  scr_analog_s an;
  int n_errors, checked, cyc;

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  scr_host_model scr_host_model_inst (.i_clock(clk), .o_wr_en(wr_en), .o_wr_addr(wa),
    .o_wr_data(wd), .o_rd_en(rd_en), .o_rd_addr(ra), .i_rd_data(rdd));

  scr_config_regs #(.WAIT_STEP_CYCLES(4)) scr_config_regs_inst (.i_clock(clk),
    .i_srst(srst), .i_wr_en(wr_en), .i_wr_addr(wa), .i_wr_data(wd), .i_rd_en(rd_en),
    .i_rd_addr(ra), .o_rd_data(rdd), .i_clear_result(clr), .i_prox_result(prx),
    .o_clear_irq(cirq), .o_prox_irq(pirq), .i_wait_start(wst), .o_wait_busy(wbusy),
    .o_wait_done(wdone), .i_prox_start(pst), .o_led_pulse(lp), .o_led_busy(lbusy),
    .o_analog(an));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    scr_host_model_inst.rd(a, q);
    chk({8'h00, q}, {8'h00, e});
  endtask

  // one result on a channel (ch 1: proximity), interrupt looked at in the next cycle
  task automatic res(input logic ch, input logic oor, input logic exp);
    @(posedge clk);
    if (ch)
      prx <= '{1'b1, oor};
    else
      clr <= '{1'b1, oor};
    @(posedge clk);
    prx <= '0;
    clr <= '0;
    #1 chk({15'h0, ch ? pirq : cirq}, {15'h0, exp});
  endtask

  function automatic int tgt(input int c);
    return c < 4 ? c : (c - 3) * 5;
  endfunction

  task automatic wt(input logic [7:0] wp, input logic st);
    int n = 0;
    scr_host_model_inst.wr(`SCR_ADDR_WAIT_PERIOD, wp, 1'b0);
    scr_host_model_inst.wr(`SCR_ADDR_WAIT_EXT, {6'h00, st, 1'b0}, 1'b0);
    @(posedge clk);
    wst <= 1'b1;
    @(posedge clk);
    wst <= 1'b0;
    #1 chk({15'h0, wbusy}, 16'h0001);
    while (wdone !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'(n), 16'((256 - wp) * (st ? 12 : 1) * 4));
    chk({15'h0, wbusy}, 16'h0000);
  endtask

  task automatic led(input logic [7:0] pc);
    int hi = 0;
    int ed = 0;
    int n = 0;
    logic prev = 1'b0;
    scr_host_model_inst.wr(`SCR_ADDR_PULSE_NUM, pc, 1'b0);
    @(posedge clk);
    pst <= 1'b1;
    @(posedge clk);
    pst <= 1'b0;
    #1 chk({15'h0, lbusy}, {15'h0, pc != 8'h00});
    while (lbusy === 1'b1 && n < 2000)
    begin
      hi += (lp === 1'b1);
      ed += (lp === 1'b1 && !prev);
      prev = (lp === 1'b1);
      @(posedge clk);
      #1 n++;
    end
    chk(16'(hi), 16'(80 * pc));
    chk(16'(ed), {8'h00, pc});
  endtask

  initial
  begin
    srst = 1'b1;
    wst = 1'b0;
    pst = 1'b0;
    clr = '0;
    prx = '0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rc(`SCR_ADDR_WAIT_PERIOD, 8'hff);
    rc(`SCR_ADDR_PERSIST, 8'h00);
    rc(`SCR_ADDR_WAIT_EXT, 8'h00);
    rc(`SCR_ADDR_PULSE_NUM, 8'h00);
    rc(`SCR_ADDR_ANALOG, 8'h00);
    scr_host_model_inst.wr(8'h10, 8'hff, 1'b1);
    rc(8'h10, 8'h00);
    scr_host_model_inst.wr(`SCR_ADDR_WAIT_EXT, 8'hff, 1'b1);
    rc(`SCR_ADDR_WAIT_EXT, 8'h02);
    scr_host_model_inst.wr(`SCR_ADDR_ANALOG, 8'hff, 1'b1);
    rc(`SCR_ADDR_ANALOG, 8'hc3);
    for (int k = 0; k < 4; k++)
    begin
      scr_host_model_inst.wr(`SCR_ADDR_ANALOG, {2'(k), 4'h0, 2'(3 - k)}, 1'b0);
      #1 chk({12'h0, an}, {12'h0, 2'(k), 2'(3 - k)});
    end
    scr_host_model_inst.wr(`SCR_ADDR_PERSIST, 8'h00, 1'b0);
    res(1'b0, 1'b0, 1'b1);
    res(1'b1, 1'b0, 1'b1);
    scr_host_model_inst.wr(`SCR_ADDR_PERSIST, 8'h01, 1'b0);
    res(1'b0, 1'b0, 1'b0);
    res(1'b0, 1'b1, 1'b1);
    for (int c = 2; c < 16; c++)
    begin
      scr_host_model_inst.wr(`SCR_ADDR_PERSIST, {4'h0, 4'(c)}, 1'b0);
      res(1'b0, 1'b0, 1'b0);
      repeat (tgt(c) - 1) res(1'b0, 1'b1, 1'b0);
      res(1'b0, 1'b0, 1'b0);
      repeat (tgt(c) - 1) res(1'b0, 1'b1, 1'b0);
      res(1'b0, 1'b1, 1'b1);
    end
    scr_host_model_inst.wr(`SCR_ADDR_PERSIST, 8'h30, 1'b0);
    res(1'b1, 1'b0, 1'b0);
    repeat (2) res(1'b1, 1'b1, 1'b0);
    res(1'b1, 1'b1, 1'b1);
    res(1'b0, 1'b0, 1'b1);
    scr_host_model_inst.wr(`SCR_ADDR_PERSIST, 8'h10, 1'b0);
    res(1'b1, 1'b1, 1'b1);
    wt(8'hfe, 1'b0);
    wt(8'hfd, 1'b1);
    led(8'h03);
    led(8'h00);
    results();
  end
endmodule
`default_nettype wire
